// ===== hw/rnfb_pkg.sv
// Purpose: Constants, types and helpers for the resonance notch filter bank
// Assumes: 200 MHz pclk, APB register access, one sample strobe per filter sample
// Notes:
// How it works
// - Notch frequencies accepted only 10..4500 Hz
// - Up to five independent programmable notch stages
// - Stage attenuates centre frequency, own depth/width
// - Stage one active only in manual tuning
// - Stages two-five active when enable digit 1
// - Stage four enabled forces shaft filter off
// - Shaft filter enabled after reset
// - Robust filter enabled keeps stage five off
// - Robust filter disabled after reset
// - Tuning mode: 0 off, 1 auto, 2 manual
// - Auto tuning injects excitation for seconds
// - Detection at most ten seconds, then program
// - Tuning end rewrites mode to 2 or 0
// - Auto tuning finds frequency and depth itself
// - Auto depth chosen from current gain setting
// - Auto search covers 100 Hz to 2245 Hz
// - Tough drive rewrites only stage 1/2 frequency
// - Shaft auto frequency from motor and inertia
// - Shaft codes 00/01 disabled, 02 is 4500 Hz
`default_nettype none
package rnfb_pkg;

  localparam int          NSTAGE       = 5;
  localparam int          CLK_HZ       = 200_000_000;
  localparam int          SAMPLE_HZ    = 50_000;

  // Register byte offsets
  localparam logic [7:0]  OFS_TUNE     = 8'h00;
  localparam logic [7:0]  OFS_N1_FREQ  = 8'h04;
  localparam logic [7:0]  OFS_N5_SHAPE = 8'h28;
  localparam logic [7:0]  OFS_ROBUST   = 8'h2c;
  localparam logic [7:0]  OFS_SHAFT_F  = 8'h30;
  localparam logic [7:0]  OFS_FILT_SEL = 8'h34;
  localparam logic [7:0]  OFS_GAIN     = 8'h38;
  localparam logic [7:0]  OFS_STATUS   = 8'h3c;

  // Tuning mode values
  localparam logic [1:0]  TUNE_OFF     = 2'h0;
  localparam logic [1:0]  TUNE_AUTO    = 2'h1;
  localparam logic [1:0]  TUNE_MANUAL  = 2'h2;

  // Frequency limits in Hz
  localparam logic [12:0] FREQ_MIN     = 13'h000a;
  localparam logic [12:0] FREQ_MAX     = 13'h1194;
  localparam logic [12:0] FREQ_RESET   = 13'h1194;

  // Shape field positions
  localparam int          SH_EN        = 0;
  localparam int          SH_DEPTH_LO  = 4;
  localparam int          SH_WIDTH_LO  = 8;
  localparam logic [11:0] SHAPE_RESET  = 12'h000;

  // Shaft filter selection and codes
  localparam logic [1:0]  SHAFT_AUTO   = 2'h0;
  localparam logic [1:0]  SHAFT_MANUAL = 2'h1;
  localparam logic [1:0]  SHAFT_OFF    = 2'h2;
  localparam logic [4:0]  SHAFT_CODE_MIN = 5'h02;
  localparam logic [4:0]  SHAFT_F_RESET  = 5'h00;
  localparam logic [1:0]  FILT_SEL_RESET = 2'h0;

  // Auto tuning sweep
  localparam int          TUNE_TIME_S  = 10;
  localparam int          TUNE_NSTEP   = 16;
  localparam logic [12:0] TUNE_F_LO    = 13'h0064;
  localparam logic [12:0] TUNE_F_STEP  = 13'h008f;
  localparam logic [31:0] NCO_K        = 32'h0000_0015;
  localparam logic [15:0] EXC_AMP      = 16'h0800;
  localparam logic [39:0] DETECT_MIN   = 40'h00_0010_0000;
  localparam logic [15:0] GAIN_RESET   = 16'h0100;
  localparam logic [15:0] GAIN_HI      = 16'h0400;
  localparam logic [15:0] GAIN_MID     = 16'h0100;
  localparam logic [3:0]  DEPTH_HI     = 4'hf;
  localparam logic [3:0]  DEPTH_MID    = 4'hb;
  localparam logic [3:0]  DEPTH_LO     = 4'h7;

  // Coefficient scaling: coef = f * 2pi * 2^14 / SAMPLE_HZ
  localparam logic [12:0] COEF_NUM     = 13'h083c;
  localparam int          COEF_SHIFT   = 10;
  localparam int          FRAC         = 14;

  typedef enum logic [1:0] {TST_IDLE, TST_SWEEP, TST_DONE} rnfb_tune_state_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } rnfb_smp_t;

  typedef struct packed {
    logic        en;
    logic [15:0] coef;
    logic [15:0] damp;
    logic [3:0]  depth;
  } rnfb_cfg_t;

  function automatic logic [15:0] sat16(input logic signed [31:0] v);
    if (v > 32'sd32767) sat16 = 16'h7fff;
    else if (v < -32'sd32768) sat16 = 16'h8000;
    else sat16 = v[15:0];
  endfunction

  function automatic logic freq_ok(input logic [31:0] f);
    freq_ok = (f >= 32'(FREQ_MIN)) && (f <= 32'(FREQ_MAX));
  endfunction

  function automatic logic [15:0] freq_coef(input logic [12:0] f);
    logic [25:0] p;
    p = 26'(f) * 26'(COEF_NUM);
    freq_coef = 16'(p >> COEF_SHIFT);
  endfunction

endpackage
`default_nettype wire

// ===== hw/rnfb_notch_stage.sv
// Purpose: One state-variable notch stage, state advanced per sample strobe
// Assumes: cfg is stable between strobes
// Notes: Combinational output, registered state
`timescale 1ns/1ps
`default_nettype none
module rnfb_notch_stage (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               strobe,
  input  wire rnfb_pkg::rnfb_cfg_t cfg,
  input  wire logic        [15:0] x,
  output logic             [15:0] y
);
  logic signed [31:0] low_reg;
  logic signed [31:0] band_reg;
  logic signed [31:0] xs;
  logic signed [31:0] hp;
  logic signed [47:0] damp_band;
  logic signed [47:0] coef_hp;
  logic signed [47:0] coef_band;
  logic signed [47:0] cut;

  assign xs        = 32'(signed'(x));
  assign damp_band = 48'(band_reg) * 48'(signed'({1'b0, cfg.damp}));
  assign hp        = xs - low_reg - 32'(damp_band >>> rnfb_pkg::FRAC);
  assign coef_hp   = 48'(hp) * 48'(signed'({1'b0, cfg.coef}));
  assign coef_band = 48'(band_reg) * 48'(signed'({1'b0, cfg.coef}));
  // Band-pass scaled by depth is removed from the input
  assign cut       = (damp_band * 48'(signed'({1'b0, cfg.depth}))) >>> (rnfb_pkg::FRAC + 4);

  always_comb begin
    if (cfg.en) begin
      y = rnfb_pkg::sat16(xs - 32'(cut));
    end else begin
      y = x;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_reg  <= '0;
      band_reg <= '0;
    end else if (strobe) begin
      band_reg <= band_reg + 32'(coef_hp >>> rnfb_pkg::FRAC);
      low_reg  <= low_reg + 32'(coef_band >>> rnfb_pkg::FRAC);
    end
  end
endmodule
`default_nettype wire

// ===== hw/rnfb_filter_bank.sv
// Purpose: Five-stage resonance notch filter bank with adaptive tuning
// Assumes: APB slave, one sample per smp_in.valid pulse
// Notes: Config snapshot swaps at sample strobes; shaft filter only flagged
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module rnfb_filter_bank #(
  parameter logic [31:0] TUNE_CYCLES = 32'(rnfb_pkg::TUNE_TIME_S * rnfb_pkg::CLK_HZ)
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic         [7:0] paddr,
  input  wire logic        [31:0] pwdata,
  output logic             [31:0] prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire rnfb_pkg::rnfb_smp_t smp_in,
  output rnfb_pkg::rnfb_smp_t     smp_out,
  input  wire logic         [1:0] motor_type,
  input  wire logic               tough_wr_valid,
  input  wire logic               tough_wr_stage,
  input  wire logic        [12:0] tough_wr_freq,
  output logic                    shaft_active,
  output logic              [4:0] shaft_freq_code,
  output logic                    tuning_busy
);
  localparam logic [31:0] DWELL = TUNE_CYCLES / 32'(rnfb_pkg::TUNE_NSTEP);

  logic [1:0]  mode_reg;
  logic [12:0] freq_reg  [rnfb_pkg::NSTAGE];
  logic [11:0] shape_reg [rnfb_pkg::NSTAGE];
  logic        robust_reg;
  logic [4:0]  shaft_f_reg;
  logic [1:0]  filt_sel_reg;
  logic [15:0] gain_reg;
  logic [7:0]  inertia_reg;
  logic        range_err_reg;

  rnfb_pkg::rnfb_cfg_t cfg_live [rnfb_pkg::NSTAGE];
  rnfb_pkg::rnfb_cfg_t cfg_reg  [rnfb_pkg::NSTAGE];
  logic [15:0] stage_x [rnfb_pkg::NSTAGE+1];
  logic [rnfb_pkg::NSTAGE-1:0] stage_en;

  rnfb_pkg::rnfb_tune_state_t tstate_reg;
  logic [3:0]  step_reg;
  logic [31:0] dwell_reg;
  logic [31:0] phase_reg;
  logic [39:0] energy_reg;
  logic [39:0] best_e_reg;
  logic [12:0] best_f_reg;
  logic [12:0] step_freq;

  logic        acc_ph;
  logic        wr_en;
  logic [5:0]  idx;
  logic        is_stage;
  logic [2:0]  st_num;
  logic        st_freq;
  logic        mapped;
  logic        tune_start;
  logic        wr_freq_ok;
  logic        tough_ok;
  logic [4:0]  shaft_auto_code;
  logic [4:0]  shaft_eff;
  logic        err_set;
  logic [15:0] abs_in;
  logic        tune_fail;

  assign acc_ph     = psel && penable;
  assign wr_en      = acc_ph && pwrite && pready && mapped;
  assign idx        = paddr[7:2];
  assign is_stage   = (paddr >= rnfb_pkg::OFS_N1_FREQ) && (paddr <= rnfb_pkg::OFS_N5_SHAPE);
  assign st_num     = 3'((idx - 6'h01) >> 1);
  assign st_freq    = idx[0];
  assign mapped     = (paddr[1:0] == 2'h0) && (paddr <= rnfb_pkg::OFS_STATUS);
  assign wr_freq_ok = rnfb_pkg::freq_ok(pwdata);
  assign tough_ok   = rnfb_pkg::freq_ok(32'(tough_wr_freq));
  assign tune_start = wr_en && (paddr == rnfb_pkg::OFS_TUNE)
                      && (pwdata[1:0] == rnfb_pkg::TUNE_AUTO);
  assign err_set    = (wr_en && is_stage && st_freq && !wr_freq_ok)
                      || (tough_wr_valid && !tough_ok);
  assign step_freq  = 13'(rnfb_pkg::TUNE_F_LO + 13'(step_reg) * rnfb_pkg::TUNE_F_STEP);
  assign abs_in     = smp_in.data[15] ? 16'(-smp_in.data) : smp_in.data;
  assign tune_fail  = best_e_reg < rnfb_pkg::DETECT_MIN;

  // APB handshake: one wait state, answer registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= acc_ph && !pready;
      pslverr <= acc_ph && !pready && !mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (acc_ph && !pready) begin
      prdata <= '0;
      if (is_stage && st_freq) begin
        prdata <= 32'(freq_reg[st_num]);
      end else if (is_stage) begin
        prdata <= 32'(shape_reg[st_num]);
      end else begin
        unique case (paddr)
          rnfb_pkg::OFS_TUNE:     prdata <= 32'(mode_reg);
          rnfb_pkg::OFS_ROBUST:   prdata <= 32'(robust_reg);
          rnfb_pkg::OFS_SHAFT_F:  prdata <= 32'(shaft_f_reg);
          rnfb_pkg::OFS_FILT_SEL: prdata <= 32'(filt_sel_reg);
          rnfb_pkg::OFS_GAIN:     prdata <= {8'h00, inertia_reg, gain_reg};
          rnfb_pkg::OFS_STATUS:   prdata <= {23'h000000, range_err_reg, tuning_busy,
                                             shaft_active, stage_en, shaft_eff[4:0] == 5'h00};
          default:                prdata <= '0;
        endcase
      end
    end
  end

  // Tuning mode: software writes, tuner rewrites at the end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= rnfb_pkg::TUNE_OFF;
    end else if (tstate_reg == rnfb_pkg::TST_DONE) begin
      mode_reg <= tune_fail ? rnfb_pkg::TUNE_OFF : rnfb_pkg::TUNE_MANUAL;
    end else if (wr_en && (paddr == rnfb_pkg::OFS_TUNE) && (pwdata[1:0] != 2'h3)) begin
      mode_reg <= pwdata[1:0];
    end
  end

  // Stage frequencies: software, tough drive, tuner
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < rnfb_pkg::NSTAGE; i++) begin
        freq_reg[i] <= rnfb_pkg::FREQ_RESET;
      end
    end else begin
      if (wr_en && is_stage && st_freq && wr_freq_ok) begin
        freq_reg[st_num] <= pwdata[12:0];
      end
      if (tough_wr_valid && tough_ok) begin
        freq_reg[tough_wr_stage ? 1 : 0] <= tough_wr_freq;
      end
      if ((tstate_reg == rnfb_pkg::TST_DONE) && !tune_fail) begin
        freq_reg[0] <= best_f_reg;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < rnfb_pkg::NSTAGE; i++) begin
        shape_reg[i] <= rnfb_pkg::SHAPE_RESET;
      end
    end else begin
      if (wr_en && is_stage && !st_freq) begin
        shape_reg[st_num] <= pwdata[11:0];
      end
      if ((tstate_reg == rnfb_pkg::TST_DONE) && !tune_fail) begin
        // Deeper notch for higher loop gain
        if (gain_reg > rnfb_pkg::GAIN_HI) begin
          shape_reg[0][rnfb_pkg::SH_DEPTH_LO +: 4] <= rnfb_pkg::DEPTH_HI;
        end else if (gain_reg > rnfb_pkg::GAIN_MID) begin
          shape_reg[0][rnfb_pkg::SH_DEPTH_LO +: 4] <= rnfb_pkg::DEPTH_MID;
        end else begin
          shape_reg[0][rnfb_pkg::SH_DEPTH_LO +: 4] <= rnfb_pkg::DEPTH_LO;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      robust_reg   <= 1'b0;
      shaft_f_reg  <= rnfb_pkg::SHAFT_F_RESET;
      filt_sel_reg <= rnfb_pkg::FILT_SEL_RESET;
      gain_reg     <= rnfb_pkg::GAIN_RESET;
      inertia_reg  <= '0;
    end else if (wr_en) begin
      unique case (paddr)
        rnfb_pkg::OFS_ROBUST:   robust_reg   <= pwdata[0];
        rnfb_pkg::OFS_SHAFT_F:  shaft_f_reg  <= pwdata[4:0];
        rnfb_pkg::OFS_FILT_SEL: filt_sel_reg <= pwdata[1:0];
        rnfb_pkg::OFS_GAIN: begin
          gain_reg    <= pwdata[15:0];
          inertia_reg <= pwdata[23:16];
        end
        default: ;
      endcase
    end
  end

  // Range error: sticky, write 1 to clear, a new error wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      range_err_reg <= 1'b0;
    end else if (err_set) begin
      range_err_reg <= 1'b1;
    end else if (wr_en && (paddr == rnfb_pkg::OFS_STATUS) && pwdata[11]) begin
      range_err_reg <= 1'b0;
    end
  end

  // Stage enables
  always_comb begin
    stage_en[0] = (mode_reg == rnfb_pkg::TUNE_MANUAL);
    for (int i = 1; i < rnfb_pkg::NSTAGE; i++) begin
      stage_en[i] = shape_reg[i][rnfb_pkg::SH_EN];
    end
    if (robust_reg) begin
      stage_en[4] = 1'b0;
    end
  end

  always_comb begin
    for (int i = 0; i < rnfb_pkg::NSTAGE; i++) begin
      cfg_live[i].en    = stage_en[i];
      cfg_live[i].coef  = rnfb_pkg::freq_coef(freq_reg[i]);
      cfg_live[i].damp  = 16'({shape_reg[i][rnfb_pkg::SH_WIDTH_LO +: 4], 12'h000}
                             + 16'h1000);
      cfg_live[i].depth = shape_reg[i][rnfb_pkg::SH_DEPTH_LO +: 4];
    end
  end

  // Whole config set swapped at a sample strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < rnfb_pkg::NSTAGE; i++) begin
        cfg_reg[i] <= '0;
      end
    end else if (smp_in.valid) begin
      for (int i = 0; i < rnfb_pkg::NSTAGE; i++) begin
        cfg_reg[i] <= cfg_live[i];
      end
    end
  end

  assign stage_x[0] = smp_in.data;

  for (genvar g = 0; g < rnfb_pkg::NSTAGE; g++) begin : g_stage
    rnfb_notch_stage u_stage (
      .pclk    (pclk),
      .presetn (presetn),
      .strobe  (smp_in.valid),
      .cfg     (cfg_reg[g]),
      .x       (stage_x[g]),
      .y       (stage_x[g+1])
    );
  end

  // Output sample, with excitation added while tuning
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smp_out <= '0;
    end else begin
      smp_out.valid <= smp_in.valid;
      if (smp_in.valid) begin
        if (tstate_reg == rnfb_pkg::TST_SWEEP) begin
          smp_out.data <= rnfb_pkg::sat16(32'(signed'(stage_x[rnfb_pkg::NSTAGE]))
                          + (phase_reg[31] ? 32'(rnfb_pkg::EXC_AMP)
                                           : -32'(rnfb_pkg::EXC_AMP)));
        end else begin
          smp_out.data <= stage_x[rnfb_pkg::NSTAGE];
        end
      end
    end
  end

  // Adaptive tuning sweep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tstate_reg <= rnfb_pkg::TST_IDLE;
      step_reg   <= '0;
      dwell_reg  <= '0;
      phase_reg  <= '0;
      energy_reg <= '0;
      best_e_reg <= '0;
      best_f_reg <= rnfb_pkg::TUNE_F_LO;
    end else begin
      unique case (tstate_reg)
        rnfb_pkg::TST_IDLE: begin
          if (tune_start) begin
            tstate_reg <= rnfb_pkg::TST_SWEEP;
            step_reg   <= '0;
            dwell_reg  <= '0;
            energy_reg <= '0;
            best_e_reg <= '0;
          end
        end
        rnfb_pkg::TST_SWEEP: begin
          phase_reg <= phase_reg + 32'(step_freq) * rnfb_pkg::NCO_K;
          if (smp_in.valid) begin
            energy_reg <= energy_reg + 40'(abs_in);
          end
          if (wr_en && (paddr == rnfb_pkg::OFS_TUNE) && (pwdata[1:0] != rnfb_pkg::TUNE_AUTO)) begin
            tstate_reg <= rnfb_pkg::TST_IDLE;
          end else if (dwell_reg == DWELL - 32'h1) begin
            dwell_reg  <= '0;
            energy_reg <= '0;
            if (energy_reg > best_e_reg) begin
              best_e_reg <= energy_reg;
              best_f_reg <= step_freq;
            end
            if (step_reg == 4'(rnfb_pkg::TUNE_NSTEP - 1)) begin
              tstate_reg <= rnfb_pkg::TST_DONE;
            end else begin
              step_reg <= step_reg + 4'h1;
            end
          end else begin
            dwell_reg <= dwell_reg + 32'h1;
          end
        end
        rnfb_pkg::TST_DONE: begin
          tstate_reg <= rnfb_pkg::TST_IDLE;
        end
        default: tstate_reg <= rnfb_pkg::TST_IDLE;
      endcase
    end
  end

  // Shaft filter: auto code from motor type and inertia ratio
  assign shaft_auto_code = 5'(rnfb_pkg::SHAFT_CODE_MIN + {1'b0, motor_type, 2'b00}
                           + 5'(inertia_reg[7:4] > 4'h3 ? 4'h3 : inertia_reg[7:4]));
  assign shaft_eff = (filt_sel_reg == rnfb_pkg::SHAFT_AUTO) ? shaft_auto_code : shaft_f_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shaft_active    <= 1'b0;
      shaft_freq_code <= '0;
      tuning_busy     <= 1'b0;
    end else begin
      shaft_active    <= (filt_sel_reg != rnfb_pkg::SHAFT_OFF)
                         && (shaft_eff >= rnfb_pkg::SHAFT_CODE_MIN)
                         && !stage_en[3];
      shaft_freq_code <= shaft_eff;
      tuning_busy     <= (tstate_reg == rnfb_pkg::TST_SWEEP);
    end
  end
endmodule
`default_nettype wire

// ===== verification/rnfb_filter_bank_asserts.sv
// Purpose: Port-level checks for the notch filter bank
// Assumes: One clock domain, async active-low reset
// Notes: Bound from the bench top file
`timescale 1ns/1ps
`default_nettype none
module rnfb_filter_bank_asserts #(
  parameter logic [31:0] TUNE_CYCLES = 32'd160
) (
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic          [7:0] paddr,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire rnfb_pkg::rnfb_smp_t smp_in,
  input wire rnfb_pkg::rnfb_smp_t smp_out,
  input wire logic                shaft_active,
  input wire logic          [4:0] shaft_freq_code,
  input wire logic                tuning_busy
);
  logic [31:0] busy_cnt;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence apb_req;
    psel && penable && !pready;
  endsequence
  sequence apb_ans;
    pready ##1 !pready;
  endsequence
  // Length of the current sweep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) busy_cnt <= 32'h0;
    else if (tuning_busy) busy_cnt <= busy_cnt + 32'h1;
    else busy_cnt <= 32'h0;
  end
  a_apb_one_wait: assert property (apb_req |=> apb_ans)
    else $error("pready not one cycle after access");
  a_ready_has_cause: assert property (pready |-> $past(psel && penable))
    else $error("pready without access");
  a_unmapped_err: assert property ((apb_req and paddr > 8'h3c) |=> pslverr)
    else $error("unmapped access without pslverr");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr outside pready");
  a_sample_latency: assert property (smp_in.valid |=> smp_out.valid)
    else $error("sample out not one cycle after sample in");
  a_out_has_cause: assert property (smp_out.valid |-> $past(smp_in.valid))
    else $error("sample out without sample in");
  a_out_holds: assert property (!smp_out.valid |-> $stable(smp_out.data))
    else $error("output data moved between samples");
  a_shaft_code_legal: assert property (shaft_active |-> shaft_freq_code >= 5'h02)
    else $error("shaft filter active with disabled code");
  a_tune_bounded: assert property (busy_cnt <= TUNE_CYCLES + 32'h8)
    else $error("tuning sweep too long");
endmodule
`default_nettype wire

// ===== verification/rnfb_filter_bank_tb.sv
// Purpose: Self-checking bench for the notch filter bank
// Assumes: 200 MHz pclk, shortened tuning interval
// Notes: Random stimulus from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module rnfb_filter_bank_tb;
  localparam logic [31:0] TC = 32'd1600;
  logic                pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic          [7:0] paddr;
  logic         [31:0] pwdata, prdata, rd, v;
  rnfb_pkg::rnfb_smp_t smp_in, smp_out;
  logic          [1:0] motor_type;
  logic                tough_wr_valid, tough_wr_stage, shaft_active, tuning_busy;
  logic         [12:0] tough_wr_freq;
  logic         [12:0] ef [5];
  logic          [4:0] shaft_freq_code;
  logic          [5:1] en;
  int                  fail_count, samples_checked, i, k, n, r;
  int                  tbl [6] = '{9, 10, 4500, 4501, 0, 8191};
  int                  codes [4] = '{0, 1, 2, 31};

  rnfb_filter_bank #(.TUNE_CYCLES(TC)) rnfb_filter_bank_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .smp_in(smp_in), .smp_out(smp_out), .motor_type(motor_type),
    .tough_wr_valid(tough_wr_valid), .tough_wr_stage(tough_wr_stage),
    .tough_wr_freq(tough_wr_freq), .shaft_active(shaft_active),
    .shaft_freq_code(shaft_freq_code), .tuning_busy(tuning_busy));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    if (fail_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge pclk);
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int m;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    m = 0;
    do begin
      @(posedge pclk);
      m++;
    end while (pready !== 1'b1 && m < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      print_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic smp(input logic [15:0] d, input logic chk);
    @(posedge pclk);
    smp_in <= {1'b1, d};
    @(posedge pclk);
    smp_in.valid <= 1'b0;
    @(posedge pclk);
    check(32'(smp_out.valid), 32'h1);
    if (chk) check(32'(smp_out.data), 32'(d));
  endtask

  task automatic tough(input logic s, input logic [12:0] f);
    @(posedge pclk);
    tough_wr_valid <= 1'b1;
    tough_wr_stage <= s;
    tough_wr_freq <= f;
    @(posedge pclk);
    tough_wr_valid <= 1'b0;
    tick(2);
  endtask

  function automatic logic [4:0] shaft_exp(input logic [1:0] m, input logic [7:0] in);
    return 5'd2 + {1'b0, m, 2'b00} + ((in >> 4) > 8'd3 ? 5'd3 : 5'(in >> 4));
  endfunction

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  initial begin
    {presetn, psel, penable, pwrite, tough_wr_valid, tough_wr_stage} = '0;
    {paddr, pwdata, smp_in, motor_type, tough_wr_freq} = '0;
    fail_count = 0;
    samples_checked = 0;
    i = $urandom(32'h0c610b79);
    tick(5);
    presetn <= 1'b1;
    tick(2);
    check(32'(shaft_active), 32'h1);
    for (k = 0; k < 5; k++) begin
      ef[k] = 13'd4500;
      apb(1'b0, 8'(4 + 8 * k), 0);
      check(rd, 32'd4500);
      apb(1'b0, 8'(8 + 8 * k), 0);
      check(rd, 32'h0);
    end
    apb(1'b0, 8'h40, 0);
    check(32'(err), 32'h1);
    apb(1'b1, 8'h02, 32'h1);
    check(32'(err), 32'h1);
    for (i = 0; i < 12; i++) begin
      k = $urandom % 5;
      v = (i < 6) ? 32'(tbl[i]) : 32'd10 + $urandom % 4491;
      apb(1'b1, 8'(4 + 8 * k), v);
      if (v >= 10 && v <= 4500) ef[k] = v[12:0];
      apb(1'b0, 8'(4 + 8 * k), 0);
      check(rd, 32'(ef[k]));
    end
    apb(1'b0, 8'h3c, 0);
    check(32'(rd[8]), 32'h1);
    // Stage one enabled in shape, stage two has depth and width but no enable
    apb(1'b1, 8'h08, 32'h1);
    apb(1'b1, 8'h10, 32'hff0);
    en = '0;
    for (k = 1; k < 5; k++) begin
      smp(16'($urandom), k == 1);
      apb(1'b1, 8'(8 + 8 * k), 32'h0a1);
      en[k + 1] = 1'b1;
      smp(16'($urandom), 1'b0);
      apb(1'b0, 8'h3c, 0);
      check(32'(rd[5:1]), 32'(en));
      if (k == 3) check(32'(shaft_active), 32'h0);
    end
    apb(1'b1, 8'h2c, 32'h1);
    en[5] = 1'b0;
    smp(16'h0, 1'b0);
    apb(1'b0, 8'h3c, 0);
    check(32'(rd[5:1]), 32'(en));
    apb(1'b1, 8'h00, 32'h2);
    apb(1'b1, 8'h00, 32'h3);
    en[1] = 1'b1;
    smp(16'h0, 1'b0);
    apb(1'b0, 8'h3c, 0);
    check(32'(rd[5:1]), 32'(en));
    apb(1'b0, 8'h00, 0);
    check(rd, 32'h2);
    for (k = 0; k < 5; k++) apb(1'b1, 8'(8 + 8 * k), 0);
    apb(1'b1, 8'h00, 32'h0);
    tick(3);
    check(32'(shaft_active), 32'h1);
    for (i = 0; i < 4; i++) begin
      motor_type <= 2'($urandom);
      v = ($urandom & 32'h00ff_0000) | 32'h100;
      apb(1'b1, 8'h38, v);
      tick(3);
      check(32'(shaft_freq_code), 32'(shaft_exp(motor_type, v[23:16])));
    end
    apb(1'b1, 8'h34, 32'h1);
    for (i = 0; i < 4; i++) begin
      apb(1'b1, 8'h30, 32'(codes[i]));
      tick(3);
      check(32'(shaft_active), 32'(codes[i] >= 2));
      if (codes[i] >= 2) check(32'(shaft_freq_code), 32'(codes[i]));
    end
    apb(1'b1, 8'h34, 32'h2);
    tick(3);
    check(32'(shaft_active), 32'h0);
    apb(1'b1, 8'h34, 32'h0);
    tough(1'b1, 13'd500);
    apb(1'b0, 8'h0c, 0);
    check(rd, 32'd500);
    tough(1'b0, 13'd4501);
    apb(1'b0, 8'h04, 0);
    check(rd, 32'(ef[0]));
    tough(1'b0, 13'd777);
    apb(1'b0, 8'h04, 0);
    check(rd, 32'd777);
    apb(1'b0, 8'h14, 0);
    check(rd, 32'(ef[2]));
    for (r = 0; r < 2; r++) begin
      apb(1'b1, 8'h38, r ? 32'h500 : 32'h100);
      apb(1'b1, 8'h00, 32'h1);
      tick(2);
      check(32'(tuning_busy), 32'h1);
      // Silent input: output carries only the excitation
      if (r == 0) begin
        // First sample still runs on the old config snapshot
        repeat (2) smp(16'h0, 1'b0);
        check(32'(smp_out.data == 16'h0800 || smp_out.data == 16'hf800), 32'h1);
      end
      for (n = 0; n < TC + 64 && (n < 4 || tuning_busy === 1'b1); n++) begin
        @(posedge pclk);
        smp_in <= {~smp_in.valid, r ? 16'h7fff : 16'h0};
      end
      @(posedge pclk);
      smp_in.valid <= 1'b0;
      if (tuning_busy !== 1'b0) begin
        fail_count++;
        print_verdict();
      end
      apb(1'b0, 8'h00, 0);
      check(rd, r ? 32'h2 : 32'h0);
    end
    apb(1'b0, 8'h08, 0);
    check(32'(rd[7:4]), 32'hf);
    apb(1'b0, 8'h04, 0);
    check(32'(rd >= 100 && rd <= 2245), 32'h1);
    presetn <= 1'b0;
    tick(3);
    presetn <= 1'b1;
    tick(2);
    check(32'(shaft_active), 32'h1);
    apb(1'b0, 8'h2c, 0);
    check(rd, 32'h0);
    print_verdict();
  end
endmodule

bind rnfb_filter_bank rnfb_filter_bank_asserts #(.TUNE_CYCLES(TUNE_CYCLES)) chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .smp_in(smp_in), .smp_out(smp_out),
  .shaft_active(shaft_active), .shaft_freq_code(shaft_freq_code),
  .tuning_busy(tuning_busy));
`default_nettype wire
